//--- hdl/tss_sense_status.sv
// Tape drive sense status: command legality checks, fault flags, sense block.
// Assumes drive status and events come from logic on mclk; the attention line
// and the read data line are pins and are synchronised here.
`timescale 1ns/1ps

module tss_sense_status #(
  parameter int unsigned CREASE_CYC   = tss_pkg::CREASE_CYC,    // Longest crease
  parameter int unsigned NO_DATA_CYC  = tss_pkg::NO_DATA_CYC,   // 16-foot timeout
  parameter int unsigned LONG_REC_CYC = tss_pkg::LONG_REC_CYC   // 48-inch record
) (
  input  wire logic               mclk,             // Clock, 20 MHz
  input  wire logic               rst,              // Synchronous reset
  input  wire logic               ce,               // Clock enable
  input  wire logic               cmd_valid,        // Command strobe
  input  wire logic [7:0]         cmd_code,         // Command code
  output logic                    cmd_accept,       // Command accepted pulse
  output logic                    cmd_illegal,      // Command refused pulse
  input  wire tss_pkg::tss_drive_t drive,           // Drive status levels
  input  wire tss_pkg::tss_event_t events,          // Drive events and activity
  input  wire logic               attention_pin,    // Attention line, async
  input  wire logic               read_data_pin,    // Read data present, async
  input  wire logic               sense_rd,         // Sense byte read strobe
  input  wire logic [4:0]         sense_addr,       // Sense byte address
  output logic      [7:0]         sense_rdata,      // Sense byte data
  output logic                    sense_rvalid,     // Sense data valid
  output logic                    sense_pending,    // Sense waiting to be fetched
  output logic                    hard_error_flag   // Hard error interrupt status
);

  typedef struct packed {
    logic                  attn_s1;
    logic                  attn_s2;
    logic                  rdat_s1;
    logic                  rdat_s2;
    tss_pkg::tss_rd_state_t rd_st;
    tss_pkg::tss_flags_t   f;
    logic                  wrote_last;
    logic                  gate_seen;
    logic [31:0]           drop_cnt;
    logic [31:0]           wait_cnt;
    logic [31:0]           long_cnt;
    logic [7:0]            tally;
    logic                  ack;
    logic                  nak;
  } tss_state_t;

  tss_state_t r;
  tss_state_t next_r;

  logic                           is_known;
  logic                           is_read;
  logic                           is_write;
  logic                           is_sense;
  logic                           is_repos;
  logic                           illegal_now;
  logic                           sense_take;
  logic                           hard_now;
  logic [7:0]                     byte6;
  logic [7:0]                     byte7;
  logic [7:0]                     byte8;
  logic [7:0]                     byte9;
  logic [7:0]                     byte10;
  logic [tss_pkg::SENSE_BYTES*8-1:0] frame;

  // ==========================================================================
  // Command decode
  always_comb begin
    is_sense = (cmd_code == tss_pkg::CMD_SENSE);
    is_read  = (cmd_code == tss_pkg::CMD_READ);
    is_write = (cmd_code == tss_pkg::CMD_WRITE) || (cmd_code == tss_pkg::CMD_WR_FM)
            || (cmd_code == tss_pkg::CMD_ERASE);
    is_repos = (cmd_code == tss_pkg::CMD_REWIND) || (cmd_code == tss_pkg::CMD_RESTORE)
            || (cmd_code == tss_pkg::CMD_SP_REV);
    is_known = is_sense || is_read || is_write || is_repos
            || (cmd_code == tss_pkg::CMD_HEALTH);
  end

  // Legality of the command on offer; the sense fetch bypasses the pending check
  always_comb begin
    illegal_now = 1'b0;
    if (!is_known) illegal_now = 1'b1;
    if (is_read && r.wrote_last) illegal_now = 1'b1;
    if (is_read && !drive.stripe_here) illegal_now = 1'b1;
    if (sense_pending && !is_sense) illegal_now = 1'b1;
    if (is_write && drive.write_protect) illegal_now = 1'b1;
    if (drive.at_track_end && drive.last_track && !is_sense
        && cmd_code != tss_pkg::CMD_REWIND && cmd_code != tss_pkg::CMD_RESTORE) begin
      illegal_now = 1'b1;
    end
    if (cmd_code == tss_pkg::CMD_SP_REV && drive.at_track_start
        && drive.track == 4'h0) begin
      illegal_now = 1'b1;
    end
    if ((drive.health_fault || drive.defective_cart || r.attn_s2)
        && !is_sense && cmd_code != tss_pkg::CMD_HEALTH) begin
      illegal_now = 1'b1;
    end
    if (is_write && drive.cart_450ft) illegal_now = 1'b1;
  end

  assign sense_take = cmd_valid && is_sense && !illegal_now;

  // ==========================================================================
  // Sense bytes built from the sticky flags and live drive status
  assign hard_now = r.f.erase_noise || r.f.no_data || r.f.long_rec
                 || r.f.rd_lim || r.f.wr_lim || r.f.rd_rec_lim || r.f.wr_try_lim;

  always_comb begin
    byte6  = {r.f.illegal, 1'b0, hard_now, 2'b00,
              drive.health_fault, drive.defective_cart, 1'b0};
    byte7  = {drive.stripe_good, drive.retry_expected, drive.file_mark,
              drive.write_current && !drive.write_protect,
              drive.at_track_end, drive.at_track_start,
              drive.write_protect, drive.cart_present};
    byte8  = {tss_pkg::MODEL_CODE, drive.track};
    byte9  = {r.f.long_rec, r.f.raw_miss, r.f.no_gate, r.f.no_data,
              r.f.erase_noise, r.f.mk1_miss, 1'b0, r.f.crease};
    byte10 = {drive.retry_count, r.f.wr_try_lim, r.f.rd_rec_lim,
              r.f.wr_lim, r.f.rd_lim};
    frame  = '0;
    frame[tss_pkg::B_LEGAL*8   +: 8] = byte6;
    frame[tss_pkg::B_POS*8     +: 8] = byte7;
    frame[tss_pkg::B_TRACK*8   +: 8] = byte8;
    frame[tss_pkg::B_RDFAULT*8 +: 8] = byte9;
    frame[tss_pkg::B_RETRY*8   +: 8] = byte10;
    frame[tss_pkg::B_TALLY*8   +: 8] = r.tally;
  end

  // ==========================================================================
  // Next-state logic: clear on sense fetch first, then new sets win
  always_comb begin
    next_r         = r;
    next_r.attn_s1 = attention_pin;
    next_r.attn_s2 = r.attn_s1;
    next_r.rdat_s1 = read_data_pin;
    next_r.rdat_s2 = r.rdat_s1;
    next_r.ack     = cmd_valid && !illegal_now;
    next_r.nak     = cmd_valid && illegal_now;

    // Flags hold until the sense block is taken
    if (sense_take) begin
      next_r.f     = '0;
      next_r.tally = 8'h00;
    end

    // Command effects
    if (cmd_valid && illegal_now) next_r.f.illegal = 1'b1;
    if (cmd_valid && !illegal_now) begin
      if (is_write) next_r.wrote_last = 1'b1;
      if (is_repos) next_r.wrote_last = 1'b0;
    end

    // Event faults
    if (events.record_start_miss) next_r.f.mk1_miss = 1'b1;
    if (events.raw_noise && events.erase_active) next_r.f.erase_noise = 1'b1;
    if (events.raw_data_miss) next_r.f.raw_miss = 1'b1;
    if (events.rd_err_limit) next_r.f.rd_lim = 1'b1;
    if (events.wr_err_limit) next_r.f.wr_lim = 1'b1;
    if (events.rd_recov_limit) next_r.f.rd_rec_lim = 1'b1;
    if (events.wr_retry_limit) next_r.f.wr_try_lim = 1'b1;
    if (events.rd_err_inc && next_r.tally != 8'hff) begin
      next_r.tally = next_r.tally + 8'h01;
    end

    // Record length timer
    if (events.read_gate_window) begin
      if (r.long_cnt < LONG_REC_CYC) begin
        next_r.long_cnt = r.long_cnt + 32'h0000_0001;
      end else begin
        next_r.f.long_rec = 1'b1;
      end
    end else begin
      next_r.long_cnt = 32'h0000_0000;
    end

    // Read window sequencer
    if (events.read_gate_window) next_r.gate_seen = 1'b1;
    unique case (r.rd_st)
      tss_pkg::TSS_RD_IDLE: begin
        next_r.gate_seen = events.read_gate_window;
        next_r.wait_cnt  = 32'h0000_0000;
        next_r.drop_cnt  = 32'h0000_0000;
        if (events.read_active) next_r.rd_st = tss_pkg::TSS_RD_WAIT;
      end
      tss_pkg::TSS_RD_WAIT: begin
        if (r.rdat_s2) begin
          next_r.rd_st = tss_pkg::TSS_RD_DATA;
        end else if (r.wait_cnt < NO_DATA_CYC - 1) begin
          next_r.wait_cnt = r.wait_cnt + 32'h0000_0001;
        end else begin
          next_r.f.no_data = 1'b1;
        end
      end
      tss_pkg::TSS_RD_DATA: begin
        if (!r.rdat_s2) begin
          if (r.drop_cnt <= CREASE_CYC) next_r.drop_cnt = r.drop_cnt + 32'h0000_0001;
        end else begin
          // Short dropout is a crease, a longer one an interblock gap
          if (r.drop_cnt != 32'h0000_0000 && r.drop_cnt <= CREASE_CYC) begin
            next_r.f.crease = 1'b1;
          end
          next_r.drop_cnt = 32'h0000_0000;
        end
      end
      default: next_r.rd_st = tss_pkg::TSS_RD_IDLE;
    endcase
    if (r.rd_st != tss_pkg::TSS_RD_IDLE && !events.read_active) begin
      next_r.rd_st = tss_pkg::TSS_RD_IDLE;
      if (!r.gate_seen) next_r.f.no_gate = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      r       <= '0;
      r.rd_st <= tss_pkg::TSS_RD_IDLE;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Snapshot memory of the sense block
  tss_sense_mem #(
    .NBYTES (tss_pkg::SENSE_BYTES),
    .AW     (5)
  ) u_mem (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .capture (sense_take),
    .frame   (frame),
    .rd      (sense_rd),
    .addr    (sense_addr),
    .rdata   (sense_rdata),
    .rvalid  (sense_rvalid)
  );

  // Outputs
  assign cmd_accept      = r.ack;
  assign cmd_illegal     = r.nak;
  assign sense_pending   = r.f != '0;
  assign hard_error_flag = hard_now;

  // ==========================================================================
  // Assertions
  a_unknown_cmd: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && !is_known |=> cmd_illegal && r.f.illegal)
    else $error("unknown command not flagged");
  a_read_after_wr: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && is_read && r.wrote_last |=> cmd_illegal)
    else $error("read after write accepted");
  a_read_no_stripe: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && is_read && !drive.stripe_here |=> cmd_illegal)
    else $error("read without stripe accepted");
  a_pending_block: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && sense_pending && !is_sense |=> cmd_illegal && !cmd_accept)
    else $error("command accepted with sense pending");
  a_write_protect: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && is_write && drive.write_protect |=> cmd_illegal)
    else $error("write on protected cartridge accepted");
  a_end_state: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && drive.at_track_end && drive.last_track && is_read |=> cmd_illegal)
    else $error("read at tape end accepted");
  a_reverse_start: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && cmd_code == tss_pkg::CMD_SP_REV && drive.at_track_start
    && drive.track == 4'h0 |=> cmd_illegal)
    else $error("reverse at track zero start accepted");
  a_health_lock: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && drive.health_fault && is_write |=> cmd_illegal)
    else $error("command accepted during health fault");
  a_short_cart: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && is_write && drive.cart_450ft |=> cmd_illegal)
    else $error("write on short cartridge accepted");
  a_erase_hard: assert property (@(posedge mclk) disable iff (rst)
    ce && events.raw_noise && events.erase_active |=> hard_error_flag && sense_pending)
    else $error("erase noise did not raise hard error");
  a_gate_missing: assert property (@(posedge mclk) disable iff (rst)
    ce && r.rd_st == tss_pkg::TSS_RD_DATA && !events.read_active && !r.gate_seen
    |=> r.f.no_gate)
    else $error("missing read gate not flagged");
  a_flag_hold: assert property (@(posedge mclk) disable iff (rst)
    ce && r.f.illegal && !sense_take |=> r.f.illegal)
    else $error("illegal flag dropped before fetch");
  a_sense_answer: assert property (@(posedge mclk) disable iff (rst)
    ce && sense_rd |=> sense_rvalid)
    else $error("sense read not answered");

  // Fault flags, write current display and the attention lock
  a_mark_miss: assert property (@(posedge mclk) disable iff (rst)
    ce && events.record_start_miss |=> r.f.mk1_miss)
    else $error("record start miss not flagged");
  a_raw_miss: assert property (@(posedge mclk) disable iff (rst)
    ce && events.raw_data_miss |=> r.f.raw_miss)
    else $error("written data miss not flagged");
  a_limit_hard: assert property (@(posedge mclk) disable iff (rst)
    ce && (events.rd_err_limit || events.wr_err_limit || events.rd_recov_limit
    || events.wr_retry_limit) |=> hard_error_flag)
    else $error("limit did not raise hard error");
  a_long_record: assert property (@(posedge mclk) disable iff (rst)
    ce && events.read_gate_window && r.long_cnt >= LONG_REC_CYC |=> r.f.long_rec)
    else $error("long record not flagged");
  a_no_data: assert property (@(posedge mclk) disable iff (rst)
    ce && r.rd_st == tss_pkg::TSS_RD_WAIT && !r.rdat_s2
    && r.wait_cnt >= NO_DATA_CYC - 1 |=> r.f.no_data)
    else $error("read data timeout not flagged");
  a_wp_current: assert property (@(posedge mclk) disable iff (rst)
    drive.write_protect |-> !byte7[4])
    else $error("write current shown on protected cartridge");
  a_attn_lock: assert property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && r.attn_s2 && !is_sense && cmd_code != tss_pkg::CMD_HEALTH
    |=> cmd_illegal)
    else $error("command accepted during attention");

  c_crease: cover property (@(posedge mclk) disable iff (rst) ce && !r.f.crease ##1 r.f.crease);
  c_illegal: cover property (@(posedge mclk) disable iff (rst) cmd_illegal);
  c_fetch: cover property (@(posedge mclk) disable iff (rst) ce && sense_take ##1 !sense_pending);
  c_no_data: cover property (@(posedge mclk) disable iff (rst) r.f.no_data);
  c_no_gate: cover property (@(posedge mclk) disable iff (rst) r.f.no_gate);

endmodule

//--- hdl/tss_pkg.sv
// Package for the tape sense status block: constants, command codes and carriers.
// Assumes a single 20 MHz clock; all users write tss_pkg::name.
package tss_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ      = 20_000_000;    // Clock rate in Hz
  localparam int unsigned CLK_NS      = 50;            // Clock period in ns
  localparam int unsigned CREASE_NS   = 1_800_000;     // Longest crease dropout, 1.8 ms
  localparam int unsigned CREASE_CYC  = CREASE_NS / CLK_NS;  // Round down
  localparam int unsigned TAPE_IPS    = 90;            // Tape speed in inches per second
  localparam int unsigned NO_DATA_IN  = 16 * 12;       // 16 feet of tape, in inches
  localparam int unsigned LONG_REC_IN = 48;            // Longest record, in inches
  localparam longint unsigned NO_DATA_CYC_L  = (64'(NO_DATA_IN) * 64'(CLK_HZ)) / 64'(TAPE_IPS);
  localparam longint unsigned LONG_REC_CYC_L = (64'(LONG_REC_IN) * 64'(CLK_HZ)) / 64'(TAPE_IPS);
  localparam int unsigned NO_DATA_CYC  = 32'(NO_DATA_CYC_L);
  localparam int unsigned LONG_REC_CYC = 32'(LONG_REC_CYC_L);

  // ==========================================================================
  // Sense block layout
  localparam int unsigned SENSE_BYTES = 22;            // Bytes in a sense block
  localparam int unsigned B_LEGAL     = 6;             // command_legality_sense
  localparam int unsigned B_POS       = 7;             // cartridge_position_sense
  localparam int unsigned B_TRACK     = 8;             // track_and_model_sense
  localparam int unsigned B_RDFAULT   = 9;             // read_fault_sense
  localparam int unsigned B_RETRY     = 10;            // retry_limit_sense
  localparam int unsigned B_TALLY     = 11;            // read_error_tally
  localparam logic [7:0]  SENSE_RST   = 8'h00;         // Every sense byte after reset
  localparam logic [3:0]  MODEL_CODE  = 4'h5;          // Arbitrary value

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_SENSE   = 8'h03;
  localparam logic [7:0] CMD_REWIND  = 8'h01;
  localparam logic [7:0] CMD_RESTORE = 8'h02;
  localparam logic [7:0] CMD_READ    = 8'h08;
  localparam logic [7:0] CMD_WRITE   = 8'h0a;
  localparam logic [7:0] CMD_WR_FM   = 8'h10;
  localparam logic [7:0] CMD_ERASE   = 8'h19;
  localparam logic [7:0] CMD_SP_REV  = 8'h11;
  localparam logic [7:0] CMD_HEALTH  = 8'h1d;

  // Read window sequencer, states coded 0, 1 and 3
  typedef enum logic [1:0] {
    TSS_RD_IDLE = 2'h0,
    TSS_RD_WAIT = 2'h1,
    TSS_RD_DATA = 2'h3
  } tss_rd_state_t;

  // Drive status levels from the drive logic
  typedef struct packed {
    logic       cart_present;
    logic       write_protect;
    logic       at_track_start;
    logic       at_track_end;
    logic       write_current;
    logic       file_mark;
    logic       retry_expected;
    logic       stripe_good;
    logic [3:0] track;
    logic       last_track;
    logic       cart_450ft;
    logic       stripe_here;
    logic       health_fault;
    logic       defective_cart;
    logic [3:0] retry_count;
  } tss_drive_t;

  // Drive activity levels and one-cycle fault events
  typedef struct packed {
    logic read_active;
    logic erase_active;
    logic read_gate_window;
    logic record_start_miss;
    logic raw_noise;
    logic raw_data_miss;
    logic rd_err_limit;
    logic wr_err_limit;
    logic rd_recov_limit;
    logic wr_retry_limit;
    logic rd_err_inc;
  } tss_event_t;

  // Sticky sense flags
  typedef struct packed {
    logic illegal;
    logic crease;
    logic mk1_miss;
    logic erase_noise;
    logic no_data;
    logic no_gate;
    logic raw_miss;
    logic long_rec;
    logic rd_lim;
    logic wr_lim;
    logic rd_rec_lim;
    logic wr_try_lim;
  } tss_flags_t;

endpackage

//--- hdl/tss_sense_mem.sv
// Snapshot memory of the sense block; a capture loads every byte at once.
// Assumes capture and reads come from logic on the same clock.
`timescale 1ns/1ps
module tss_sense_mem #(
  parameter int unsigned NBYTES = tss_pkg::SENSE_BYTES,
  parameter int unsigned AW     = 5
) (
  input  wire logic              mclk,     // Clock
  input  wire logic              rst,      // Synchronous reset
  input  wire logic              ce,       // Clock enable
  input  wire logic              capture,  // Load the whole frame
  input  wire logic [NBYTES*8-1:0] frame,  // Frame to store
  input  wire logic              rd,       // Read strobe
  input  wire logic [AW-1:0]     addr,     // Byte address
  output logic      [7:0]        rdata,    // Registered read data
  output logic                   rvalid    // Read data valid
);

  typedef struct packed {
    logic [NBYTES*8-1:0] mem;
    logic [7:0]          rdata;
    logic                rvalid;
  } tss_mem_state_t;

  tss_mem_state_t r;
  tss_mem_state_t next_r;

  // ==========================================================================
  // Capture and read
  always_comb begin
    next_r        = r;
    next_r.rvalid = rd;
    if (capture) begin
      next_r.mem = frame;
    end
    if (rd) begin
      // Out-of-range bytes read as zero
      next_r.rdata = (32'(addr) < NBYTES) ? r.mem[addr*8 +: 8] : 8'h00;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign rdata  = r.rdata;
  assign rvalid = r.rvalid;

endmodule

//--- verification/tss_ctl_model.sv
// Tape controller model: issues drive commands and fetches sense bytes.
// Assumes the bench calls its tasks; each answer comes one edge after a request.
`timescale 1ns/1ps
module tss_ctl_model (
  input  wire logic       mclk,         // Clock
  output logic            cmd_valid,    // Command strobe
  output logic      [7:0] cmd_code,     // Command code
  output logic            sense_rd,     // Sense read strobe
  output logic      [4:0] sense_addr,   // Sense byte index
  input  wire logic       cmd_illegal,  // Refusal pulse
  input  wire logic       sense_rvalid, // Read data valid
  input  wire logic [7:0] sense_rdata   // Sense byte
);
  // ==========================================================================
  // Request lines idle at time zero
  initial begin
    cmd_valid  = 1'b0;
    cmd_code   = 8'h00;
    sense_rd   = 1'b0;
    sense_addr = 5'h00;
  end

  // One command, answer taken one edge later; released code shows junk
  task automatic issue(input logic [7:0] code, output logic ill);
    @(posedge mclk) #1;
    cmd_valid = 1'b1;
    cmd_code  = code;
    @(posedge mclk) #1;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    ill       = cmd_illegal;
  endtask

  // One sense byte read; no valid strobe gives an unknown byte
  task automatic fetch(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    sense_rd   = 1'b1;
    sense_addr = a;
    @(posedge mclk) #1;
    sense_rd   = 1'b0;
    sense_addr = ~a;
    d          = sense_rvalid ? sense_rdata : 8'hxx;
  endtask
endmodule

//--- verification/tss_sense_status_tb_top.sv
// Testbench for the tape sense status block with the controller model.
// Assumes the shortened timing parameters set below.
`timescale 1ns/1ps
module tss_sense_status_tb_top;
  logic                mclk;
  logic                rst;
  tss_pkg::tss_drive_t drive;
  tss_pkg::tss_event_t events;
  logic                cv, ill, cacc, ci, srd, rv, pend, herr;
  logic                ce, attn, rdat;
  logic [7:0]          cc, rd, d;
  logic [4:0]          sa;
  int                  n_errors, check_count;

  tss_sense_status #(.CREASE_CYC(20), .NO_DATA_CYC(50), .LONG_REC_CYC(30)) i_tss_sense_status (
    .mclk(mclk), .rst(rst), .ce(ce), .cmd_valid(cv), .cmd_code(cc), .cmd_accept(cacc),
    .cmd_illegal(ci), .drive(drive), .events(events), .attention_pin(attn),
    .read_data_pin(rdat), .sense_rd(srd), .sense_addr(sa), .sense_rdata(rd),
    .sense_rvalid(rv), .sense_pending(pend), .hard_error_flag(herr));
  tss_ctl_model i_tss_ctl_model (.mclk(mclk), .cmd_valid(cv), .cmd_code(cc), .sense_rd(srd),
    .sense_addr(sa), .cmd_illegal(ci), .sense_rvalid(rv), .sense_rdata(rd));

  // ==========================================================================
  // Clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Command with expected refusal
  task automatic cmd(input logic [7:0] c, input logic e);
    i_tss_ctl_model.issue(c, ill);
    chk(8'(ill), 8'(e));
    chk(8'(cacc), 8'(ce && !e));
  endtask

  // Fetch sense first, then check byte 6
  task automatic sense6(input logic [7:0] e);
    cmd(tss_pkg::CMD_SENSE, 1'b0);
    i_tss_ctl_model.fetch(5'd6, d);
    chk(d, e);
  endtask

  task automatic t_unknown;
    cmd(8'h55, 1'b1);
    chk(8'(pend), 8'h01);
    cmd(tss_pkg::CMD_REWIND, 1'b1);
    sense6(8'h80);
    i_tss_ctl_model.fetch(5'd22, d);
    chk(d, 8'h00);
  endtask

  task automatic t_order;
    drive.stripe_here = 1'b1;
    cmd(tss_pkg::CMD_WRITE, 1'b0);
    cmd(tss_pkg::CMD_READ, 1'b1);
    sense6(8'h80);
    cmd(tss_pkg::CMD_REWIND, 1'b0);
    drive.stripe_here = 1'b0;
    cmd(tss_pkg::CMD_READ, 1'b1);
    sense6(8'h80);
    drive.stripe_here   = 1'b1;
    drive.write_protect = 1'b1;
    cmd(tss_pkg::CMD_ERASE, 1'b1);
    sense6(8'h80);
    drive.write_protect = 1'b0;
    drive.cart_450ft    = 1'b1;
    cmd(tss_pkg::CMD_WR_FM, 1'b1);
    sense6(8'h80);
    drive.cart_450ft = 1'b0;
  endtask

  task automatic t_modes;
    drive.at_track_end = 1'b1;
    drive.last_track   = 1'b1;
    cmd(tss_pkg::CMD_READ, 1'b1);
    sense6(8'h80);
    cmd(tss_pkg::CMD_RESTORE, 1'b0);
    drive = '{at_track_start: 1'b1, default: '0};
    cmd(tss_pkg::CMD_SP_REV, 1'b1);
    sense6(8'h80);
    drive.track = 4'h1;
    cmd(tss_pkg::CMD_SP_REV, 1'b0);
    drive.health_fault = 1'b1;
    cmd(tss_pkg::CMD_REWIND, 1'b1);
    sense6(8'h84);
    cmd(tss_pkg::CMD_HEALTH, 1'b0);
    drive = '0;
  endtask

  task automatic t_status;
    drive = '{cart_present: 1'b1, write_protect: 1'b1, write_current: 1'b1, file_mark: 1'b1,
              stripe_good: 1'b1, track: 4'h9, retry_count: 4'h6, default: '0};
    sense6(8'h00);
    i_tss_ctl_model.fetch(5'd7, d);
    chk(d, 8'ha3);
    i_tss_ctl_model.fetch(5'd8, d);
    chk(d, {tss_pkg::MODEL_CODE, 4'h9});
    drive.write_protect = 1'b0;
    sense6(8'h00);
    i_tss_ctl_model.fetch(5'd7, d);
    chk(d, 8'hb1);
    i_tss_ctl_model.fetch(5'd10, d);
    chk(d, 8'h60);
    drive = '0;
  endtask

  task automatic t_faults;
    events.erase_active = 1'b1;
    @(posedge mclk) #1;
    events = '{erase_active: 1'b1, raw_noise: 1'b1, rd_err_inc: 1'b1, record_start_miss: 1'b1,
               raw_data_miss: 1'b1, rd_err_limit: 1'b1, wr_err_limit: 1'b1,
               rd_recov_limit: 1'b1, wr_retry_limit: 1'b1, default: 1'b0};
    @(posedge mclk) #1;
    events = '{read_gate_window: 1'b1, default: 1'b0};
    repeat (40) @(posedge mclk);
    #1;
    events.read_gate_window = 1'b0;
    chk(8'(herr), 8'h01);
    chk(8'(pend), 8'h01);
    sense6(8'h20);
    i_tss_ctl_model.fetch(5'd9, d);
    chk(d, 8'hcc);
    i_tss_ctl_model.fetch(5'd10, d);
    chk(d, 8'h0f);
    i_tss_ctl_model.fetch(5'd11, d);
    chk(d, 8'h01);
    chk(8'(herr), 8'h00);
  endtask

  // Clock enable freeze, then the attention pin lock
  task automatic t_attn;
    ce = 1'b0;
    cmd(8'h55, 1'b0);                  // Frozen: no answer
    chk(8'(pend), 8'h00);              // Frozen: no flag
    ce   = 1'b1;
    attn = 1'b1;
    repeat (2) @(posedge mclk);
    #1 cmd(tss_pkg::CMD_REWIND, 1'b1);
    sense6(8'h80);
    cmd(tss_pkg::CMD_HEALTH, 1'b0);
    attn = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // Read window faults through the read data pin
  task automatic t_read;
    events = '{read_active: 1'b1, read_gate_window: 1'b1, default: 1'b0};
    @(posedge mclk) #1;
    events.read_gate_window = 1'b0;
    repeat (60) @(posedge mclk);
    #1 chk(8'(herr), 8'h01);
    events = '0;
    repeat (2) @(posedge mclk);
    #1 sense6(8'h20);
    i_tss_ctl_model.fetch(5'd9, d);
    chk(d, 8'h10);
    events = '{read_active: 1'b1, default: 1'b0};
    rdat   = 1'b1;
    repeat (4) @(posedge mclk);
    #1 rdat = 1'b0;
    repeat (30) @(posedge mclk);
    #1 rdat = 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk(8'(pend), 8'h00);
    rdat = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rdat = 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk(8'(pend), 8'h01);
    events = '0;
    rdat   = 1'b0;
    repeat (2) @(posedge mclk);
    #1 sense6(8'h00);
    i_tss_ctl_model.fetch(5'd9, d);
    chk(d, 8'h21);
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence after a 10-cycle reset
  initial begin
    n_errors = 0;
    check_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    attn = 1'b0;
    rdat = 1'b0;
    drive = '0;
    events = '0;
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    t_unknown;
    t_order;
    t_modes;
    t_status;
    t_faults;
    t_attn;
    t_read;
    test_done;
  end

  // Watchdog, far beyond the expected run
  initial begin
    #100us;
    n_errors++;
    test_done;
  end
endmodule
